// File: hdl/ssf_holdoff.sv
// ssf_holdoff: counts from reset release, reports done when the span passes.
// assumes restart is a level that holds the counter at zero while high.
`timescale 1ns/10ps
`default_nettype none
module ssf_holdoff
    import ssf_pkg::*;
#(
    parameter longint unsigned SPAN = FAN_HOLDOFF_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic restart,
    output logic done
);
    localparam int unsigned CW = $clog2(SPAN + 1);
    localparam logic [CW-1:0] LAST = CW'(SPAN);

    logic [CW-1:0] cnt_r;
    logic done_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else if (restart) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else if (cnt_r >= LAST) begin
            done_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    assign done = done_r;
endmodule
`default_nettype wire

// File: hdl/ssf_pkg.sv
// ssf_pkg: constants shared by the supply status and fault flag logic.
// assumes a single 100 MHz pclk domain.
package ssf_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 100;
    // fan fault hold-off after turn-on, in milliseconds
    localparam int unsigned FAN_HOLDOFF_MS = 5000;
    localparam longint unsigned FAN_HOLDOFF_CYC = longint'(FAN_HOLDOFF_MS) * 1000 * CLK_MHZ;
    // input synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // apb register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_INPUTS = 8'h0C;

    // ------------------------------------------------------------
    // field positions, shared by status, irq status and irq mask
    // ------------------------------------------------------------
    localparam int unsigned BIT_SRC = 0;
    localparam int unsigned BIT_OUT = 1;
    localparam int unsigned BIT_FAN = 2;
    localparam int unsigned BIT_OT = 3;
    localparam int unsigned NUM_FLAGS = 4;

    // condition inputs field positions (raw synchronised view)
    localparam int unsigned IN_BULK = 0;
    localparam int unsigned IN_OV5 = 1;
    localparam int unsigned IN_UV5 = 2;
    localparam int unsigned IN_WIN1 = 3;
    localparam int unsigned IN_UC70 = 4;
    localparam int unsigned IN_OC85 = 5;
    localparam int unsigned IN_FAN = 6;
    localparam int unsigned IN_OT = 7;
    localparam int unsigned IN_PWR = 8;
    localparam int unsigned NUM_IN = 9;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] RST_FAULTS = 4'h3;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;

    // output fault decision cause
    typedef enum logic [1:0] {
        SSF_CAUSE_NONE,
        SSF_CAUSE_VOLT,
        SSF_CAUSE_CURR
    } ssf_cause_t;

endpackage

// File: hdl/ssf_sync.sv
// ssf_sync: multi-bit level synchroniser, one chain per bit.
// assumes inputs are independent slow levels; no bus coherency implied.
`timescale 1ns/10ps
`default_nettype none
module ssf_sync
    import ssf_pkg::*;
#(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule
`default_nettype wire

// File: hdl/ssf_top.sv
// ssf_top: status indicators and relay contact flags of a switching supply.
// assumes condition inputs come from analog comparators, asynchronous to
// pclk, and that relay coils and lamp drivers follow these outputs directly.
//
// Summary of operation
// - normal NC closed NO open; fault reverses
// - unpowered: source and output show fault
// - unpowered: fan, over_temperature_flag contacts rest normal
// - fan, over_temperature_flag start normal at turn-on
// - four lamps, colours per flag, dark unpowered
// - source fault until bulk above 390V
// - source fault precedes regulation loss by 5ms
// - source fault latched until bulk recovers
// - outside 5 percent window faults output
// - below 70 percent share faults output
// - overvoltage with undercurrent is no fault
// - clear at 1 percent or 85 percent
// - output lamp and contacts share decision
// - fan fault held off 5 s, self clears
// - over_temperature_flag fault with shutdown, self clears
`timescale 1ns/10ps
`default_nettype none
module ssf_top
    import ssf_pkg::*;
#(
    parameter longint unsigned FAN_HOLDOFF = FAN_HOLDOFF_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // comparator conditions
    input wire logic bias_power_ok,
    input wire logic bulk_above_390v,
    input wire logic out_over_5pct,
    input wire logic out_under_5pct,
    input wire logic out_within_1pct,
    input wire logic share_below_70pct,
    input wire logic share_above_85pct,
    input wire logic fan_stopped,
    input wire logic heatsink_hot,
    // front panel lamps
    output logic lamp_power_green,
    output logic lamp_output_fault_red,
    output logic lamp_fan_fault_red,
    output logic lamp_over_temp_amber,
    // relay contacts, 1 = closed
    output logic src_power_nc,
    output logic src_power_no,
    output logic output_fault_nc,
    output logic output_fault_no,
    output logic fan_fault_nc,
    output logic fan_fault_no,
    output logic over_temp_nc,
    output logic over_temp_no,
    // regulator and interrupt
    output logic regulator_shutdown,
    output logic irq
);
    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic [NUM_IN-1:0] raw_in;
    logic [NUM_IN-1:0] syn;

    assign raw_in = {bias_power_ok, heatsink_hot, fan_stopped, share_above_85pct,
                     share_below_70pct, out_within_1pct, out_under_5pct,
                     out_over_5pct, bulk_above_390v};

    ssf_sync #(
        .WIDTH(NUM_IN),
        .RST_VAL('0)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(raw_in),
        .q(syn)
    );

    logic powered;
    assign powered = syn[IN_PWR];

    // ------------------------------------------------------------
    // source power flag
    // ------------------------------------------------------------
    logic src_fault_r;

    // bulk comparator trips early enough to give the 5ms warning; the flag
    // is set three clocks after the comparator drops: two sync stages and this register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_fault_r <= RST_FAULTS[BIT_SRC];
        end else if (!powered) begin
            src_fault_r <= 1'b1;
        end else if (syn[IN_BULK]) begin
            src_fault_r <= 1'b0;
        end else begin
            src_fault_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // output fault decision with hysteresis
    // ------------------------------------------------------------
    ssf_cause_t cause_r;
    ssf_cause_t cause_nxt;
    logic ov;
    logic uv;
    logic uc;

    assign ov = syn[IN_OV5];
    assign uv = syn[IN_UV5];
    assign uc = syn[IN_UC70];

    function automatic logic volt_trip(input logic o, input logic u, input logic c);
        // overvoltage with undercurrent marks a healthy paralleled module
        volt_trip = u || (o && !c);
    endfunction

    always_comb begin
        cause_nxt = cause_r;
        unique case (cause_r)
            SSF_CAUSE_NONE: begin
                if (volt_trip(ov, uv, uc)) begin
                    cause_nxt = SSF_CAUSE_VOLT;
                end else if (uc && !ov) begin
                    cause_nxt = SSF_CAUSE_CURR;
                end
            end
            SSF_CAUSE_VOLT: begin
                if (syn[IN_WIN1] && !volt_trip(ov, uv, uc)) begin
                    cause_nxt = (uc && !ov) ? SSF_CAUSE_CURR : SSF_CAUSE_NONE;
                end
            end
            SSF_CAUSE_CURR: begin
                if (volt_trip(ov, uv, uc)) begin
                    cause_nxt = SSF_CAUSE_VOLT;
                end else if (ov || syn[IN_OC85]) begin
                    cause_nxt = SSF_CAUSE_NONE;
                end
            end
            default: cause_nxt = SSF_CAUSE_NONE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r <= SSF_CAUSE_VOLT;
        end else if (!powered) begin
            cause_r <= SSF_CAUSE_VOLT;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    logic output_fault_flag;
    assign output_fault_flag = (cause_r != SSF_CAUSE_NONE);

    // ------------------------------------------------------------
    // fan and overtemperature flags
    // ------------------------------------------------------------
    logic fan_armed;
    logic fan_fault_flag_r;
    logic over_temperature_flag_r;

    // hold-off restarts on every power return, not only on reset
    ssf_holdoff #(
        .SPAN(FAN_HOLDOFF)
    ) u_fan_holdoff (
        .pclk(pclk),
        .presetn(presetn),
        .restart(!powered),
        .done(fan_armed)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_fault_flag_r <= RST_FAULTS[BIT_FAN];
        end else begin
            // unpowered or in hold-off the flag rests normal
            fan_fault_flag_r <= powered && fan_armed && syn[IN_FAN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_temperature_flag_r <= RST_FAULTS[BIT_OT];
        end else begin
            over_temperature_flag_r <= powered && syn[IN_OT];
        end
    end

    // ------------------------------------------------------------
    // registered lamps and contacts
    // ------------------------------------------------------------
    logic [NUM_FLAGS-1:0] faults;
    logic [NUM_FLAGS-1:0] lamp_r;
    logic [NUM_FLAGS-1:0] no_r;
    logic shutdown_r;

    assign faults = {over_temperature_flag_r, fan_fault_flag_r, output_fault_flag, src_fault_r};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_r <= '0;
        end else begin
            // green means healthy; the rest light on fault; all dark unpowered
            lamp_r[BIT_SRC] <= powered && !src_fault_r;
            lamp_r[BIT_OUT] <= powered && output_fault_flag;
            lamp_r[BIT_FAN] <= powered && fan_fault_flag_r;
            lamp_r[BIT_OT] <= powered && over_temperature_flag_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            no_r <= RST_FAULTS;
        end else begin
            no_r <= faults;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shutdown_r <= 1'b1;
        end else begin
            shutdown_r <= over_temperature_flag_r || !powered;
        end
    end

    assign lamp_power_green = lamp_r[BIT_SRC];
    assign lamp_output_fault_red = lamp_r[BIT_OUT];
    assign lamp_fan_fault_red = lamp_r[BIT_FAN];
    assign lamp_over_temp_amber = lamp_r[BIT_OT];
    // each pair comes from one register bit, so nc and no never overlap
    assign src_power_no = no_r[BIT_SRC];
    assign src_power_nc = !no_r[BIT_SRC];
    assign output_fault_no = no_r[BIT_OUT];
    assign output_fault_nc = !no_r[BIT_OUT];
    assign fan_fault_no = no_r[BIT_FAN];
    assign fan_fault_nc = !no_r[BIT_FAN];
    assign over_temp_no = no_r[BIT_OT];
    assign over_temp_nc = !no_r[BIT_OT];
    assign regulator_shutdown = shutdown_r;

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    logic [NUM_FLAGS-1:0] prev_r;
    logic [NUM_FLAGS-1:0] irq_stat_r;
    logic [NUM_FLAGS-1:0] irq_mask_r;
    logic [NUM_FLAGS-1:0] rise;
    logic rd_en;
    logic wr_en;
    logic stat_rd;

    assign rd_en = psel && penable && !pwrite;
    assign wr_en = psel && penable && pwrite;
    assign stat_rd = rd_en && (paddr == OFS_IRQ_STAT);
    // prev_r resets to the reset faults, so release gives no false edge
    assign rise = no_r & ~prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= RST_FAULTS;
        end else begin
            prev_r <= no_r;
        end
    end

    // a new fault in the read cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
        end else if (stat_rd) begin
            irq_stat_r <= rise;
        end else begin
            irq_stat_r <= irq_stat_r | rise;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= RST_IRQ_MASK;
        end else if (wr_en && paddr == OFS_IRQ_MASK && pstrb[0]) begin
            irq_mask_r <= pwdata[NUM_FLAGS-1:0];
        end
    end

    // level output; masking never clears the sticky bits
    assign irq = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------
    // apb read data
    // ------------------------------------------------------------
    logic [31:0] rdata_nxt;
    logic [31:0] prdata_r;
    logic err_nxt;

    function automatic logic known_ofs(input logic [7:0] a);
        known_ofs = (a == OFS_STATUS) || (a == OFS_IRQ_STAT) ||
                    (a == OFS_IRQ_MASK) || (a == OFS_INPUTS);
    endfunction

    always_comb begin
        rdata_nxt = '0;
        unique case (paddr)
            OFS_STATUS: rdata_nxt[NUM_FLAGS-1:0] = no_r;
            OFS_IRQ_STAT: rdata_nxt[NUM_FLAGS-1:0] = irq_stat_r;
            OFS_IRQ_MASK: rdata_nxt[NUM_FLAGS-1:0] = irq_mask_r;
            OFS_INPUTS: rdata_nxt[NUM_IN-1:0] = syn;
            default: rdata_nxt = '0;
        endcase
        err_nxt = !known_ofs(paddr) || (pwrite && paddr != OFS_IRQ_MASK);
    end

    // read data captured in setup so the access phase answers at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (psel && !penable) begin
            prdata_r <= rdata_nxt;
        end
    end

    assign prdata = prdata_r;
    // no wait states: read data is already registered in setup
    assign pready = 1'b1;
    assign pslverr = psel && penable && err_nxt;
endmodule
`default_nettype wire

// File: test/ssf_relay_reader.sv
// ssf_relay_reader: user equipment reading the four form c status contacts.
// assumes 1 = contact closed; purely combinational sensing.
`timescale 1ns/10ps
`default_nettype none
module ssf_relay_reader (
    // contacts
    input wire logic src_nc,
    input wire logic src_no,
    input wire logic out_nc,
    input wire logic out_no,
    input wire logic fan_nc,
    input wire logic fan_no,
    input wire logic ot_nc,
    input wire logic ot_no,
    // decoded view
    output logic [3:0] fault,
    output logic torn
);
    // fault is read from the no side; nc must always disagree
    assign fault = {ot_no, fan_no, out_no, src_no};
    assign torn = (src_nc == src_no) | (out_nc == out_no) | (fan_nc == fan_no) | (ot_nc == ot_no);
endmodule
`default_nettype wire

// File: test/ssf_top_bench.sv
// ssf_top_bench: apb and condition-input tests of ssf_top.
// assumes relay reader model and bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module ssf_top_bench
    import ssf_pkg::*;
;
    localparam longint unsigned HOLD = 20;
    localparam logic [8:0] CLEAN = 9'h129;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, shut, irq, torn;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, lamps, no_c, nc_c, seen_f;
    logic [8:0] cond;
    logic [8:0] tin [5];
    logic [1:0] tf [5];
    int n_fail, n_checks, cycles;
    ssf_top #(.FAN_HOLDOFF(HOLD)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bias_power_ok(cond[IN_PWR]),
        .bulk_above_390v(cond[IN_BULK]), .out_over_5pct(cond[IN_OV5]),
        .out_under_5pct(cond[IN_UV5]), .out_within_1pct(cond[IN_WIN1]),
        .share_below_70pct(cond[IN_UC70]), .share_above_85pct(cond[IN_OC85]),
        .fan_stopped(cond[IN_FAN]), .heatsink_hot(cond[IN_OT]),
        .lamp_power_green(lamps[3]), .lamp_output_fault_red(lamps[2]),
        .lamp_fan_fault_red(lamps[1]), .lamp_over_temp_amber(lamps[0]),
        .src_power_nc(nc_c[0]), .src_power_no(no_c[0]), .output_fault_nc(nc_c[1]),
        .output_fault_no(no_c[1]), .fan_fault_nc(nc_c[2]), .fan_fault_no(no_c[2]),
        .over_temp_nc(nc_c[3]), .over_temp_no(no_c[3]), .regulator_shutdown(shut),
        .irq(irq));
    ssf_relay_reader u_rdr (.src_nc(nc_c[0]), .src_no(no_c[0]), .out_nc(nc_c[1]),
        .out_no(no_c[1]), .fan_nc(nc_c[2]), .fan_no(no_c[2]), .ot_nc(nc_c[3]),
        .ot_no(no_c[3]), .fault(seen_f), .torn(torn));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    // one apb transfer; read data compared only on a good read
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        input logic [31:0] exp, input logic eerr, input string what);
        logic [31:0] rd;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        check({31'h0, pslverr}, {31'h0, eerr}, what);
        if (!wr && !eerr) check(rd, exp, what);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic apply(input logic [8:0] c);
        @(posedge pclk);
        cond <= c;
        repeat (6) @(posedge pclk);
    endtask
    task automatic look(input logic pwr, input logic [3:0] f, input string what);
        logic [3:0] lit;
        lit = {pwr & ~f[0], pwr & f[1], pwr & f[2], pwr & f[3]};
        check({20'h0, lamps, no_c, nc_c}, {20'h0, lit, f, ~f}, what);
        check({27'h0, torn, seen_f}, {28'h0, f}, what);
        acc(1'b0, OFS_STATUS, 32'h0, {28'h0, f}, 1'b0, what);
    endtask
    initial begin
        n_fail = 0;
        n_checks = 0;
        cycles = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        presetn = 1'b0;
        cond = CLEAN | 9'h040;
        tin = '{CLEAN, 9'h125, 9'h119, 9'h123, 9'h113};
        tf = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h0};
        repeat (10) @(posedge pclk);
        check({20'h0, lamps, no_c, nc_c}, 32'h0000003C, "reset outputs");
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        look(1'b1, 4'h0, "fan held off");
        repeat (HOLD) @(posedge pclk);
        look(1'b1, 4'h4, "fan fault after hold-off");
        apply(CLEAN);
        look(1'b1, 4'h0, "fan resumed");
        $display("test turn-on done");
        acc(1'b0, OFS_IRQ_MASK, 32'h0, 32'h0, 1'b0, "mask reset");
        acc(1'b0, OFS_IRQ_STAT, 32'h0, 32'h4, 1'b0, "fan event");
        acc(1'b1, OFS_IRQ_MASK, 32'h1, 32'h0, 1'b0, "mask write");
        apply(CLEAN & ~9'h001);
        look(1'b1, 4'h1, "source fault");
        check({31'h0, irq}, 32'h1, "irq raised");
        acc(1'b0, OFS_IRQ_STAT, 32'h0, 32'h1, 1'b0, "irq status");
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0, "irq cleared");
        apply(CLEAN);
        look(1'b1, 4'h0, "source recovered");
        acc(1'b1, OFS_IRQ_MASK, 32'h0, 32'h0, 1'b0, "mask off");
        apply(CLEAN | 9'h080);
        look(1'b1, 4'h8, "overtemperature");
        check({30'h0, shut, irq}, 32'h2, "shutdown, irq masked");
        apply(CLEAN);
        look(1'b1, 4'h0, "cooled");
        check({31'h0, shut}, 32'h0, "shutdown released");
        $display("test source and temperature done");
        for (int i = 0; i < 5; i++) begin
            apply(tin[i]);
            look(1'b1, {2'h0, tf[i]}, "fault table");
            apply(CLEAN);
            look(1'b1, 4'h0, "fault table clear");
        end
        apply(9'h125);
        apply(9'h121);
        look(1'b1, 4'h2, "voltage hysteresis");
        apply(CLEAN);
        apply(9'h119);
        apply(9'h109);
        look(1'b1, 4'h2, "current hysteresis");
        apply(CLEAN);
        look(1'b1, 4'h0, "hysteresis released");
        $display("test output fault done");
        apply(9'h0C0);
        look(1'b0, 4'h3, "unpowered");
        check({31'h0, shut}, 32'h1, "unpowered shutdown");
        apply(CLEAN | 9'h040);
        look(1'b1, 4'h0, "power back, fan held off");
        acc(1'b1, OFS_STATUS, 32'hF, 32'h0, 1'b1, "status write refused");
        acc(1'b0, 8'h10, 32'h0, 32'h0, 1'b1, "unmapped read");
        acc(1'b1, OFS_IRQ_MASK, 32'hF, 32'h0, 1'b0, "mask write");
        acc(1'b0, OFS_IRQ_MASK, 32'h0, 32'hF, 1'b0, "mask readback");
        acc(1'b0, OFS_INPUTS, 32'h0, {23'h0, CLEAN | 9'h040}, 1'b0, "inputs view");
        $display("test register access done");
        conclude();
    end
endmodule
`default_nettype wire

// File: test/ssf_top_sva.sv
// ssf_top_sva: port-level checks of the status flag block.
// assumes a single pclk domain; bound into every ssf_top.
`timescale 1ns/10ps
`default_nettype none
module ssf_top_sva
    import ssf_pkg::*;
#(
    parameter longint unsigned FAN_HOLDOFF = FAN_HOLDOFF_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    // conditions
    input wire logic bias_power_ok,
    input wire logic bulk_above_390v,
    input wire logic out_under_5pct,
    input wire logic fan_stopped,
    input wire logic heatsink_hot,
    // indications
    input wire logic lamp_power_green,
    input wire logic lamp_output_fault_red,
    input wire logic lamp_fan_fault_red,
    input wire logic lamp_over_temp_amber,
    input wire logic src_power_nc,
    input wire logic src_power_no,
    input wire logic output_fault_nc,
    input wire logic output_fault_no,
    input wire logic fan_fault_nc,
    input wire logic fan_fault_no,
    input wire logic over_temp_nc,
    input wire logic over_temp_no,
    input wire logic regulator_shutdown
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    longint unsigned hold_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_r <= '0;
        end else if (hold_cnt_r < FAN_HOLDOFF) begin
            hold_cnt_r <= hold_cnt_r + 1;
        end
    end
    // five samples cover two sync stages, flag and output register
    sequence held_s(c);
        c [*5];
    endsequence
    contacts_apart_a: assert property (
        (src_power_nc != src_power_no) && (output_fault_nc != output_fault_no)
        && (fan_fault_nc != fan_fault_no) && (over_temp_nc != over_temp_no))
        else $error("contact pair not complementary");
    dark_unpowered_a: assert property (
        held_s(!bias_power_ok) |-> src_power_no && output_fault_no && !fan_fault_no
        && !over_temp_no && !(lamp_power_green | lamp_output_fault_red
        | lamp_fan_fault_red | lamp_over_temp_amber))
        else $error("unpowered state wrong");
    green_follows_a: assert property (
        held_s(bias_power_ok) |-> lamp_power_green == src_power_nc)
        else $error("green lamp disagrees with source contacts");
    src_latched_a: assert property (
        held_s(!bulk_above_390v) |-> src_power_no)
        else $error("source fault missing while bulk low");
    src_clears_a: assert property (
        held_s(bias_power_ok && bulk_above_390v) |-> !src_power_no)
        else $error("source fault stuck with bulk good");
    under_faults_a: assert property (
        held_s(bias_power_ok && out_under_5pct) |-> output_fault_no)
        else $error("undervoltage not flagged");
    lamp_agrees_a: assert property (
        held_s(bias_power_ok) |-> lamp_output_fault_red == output_fault_no)
        else $error("output lamp and contacts disagree");
    hot_shutdown_a: assert property (
        held_s(bias_power_ok && heatsink_hot) |-> over_temp_no && regulator_shutdown
        && lamp_over_temp_amber)
        else $error("overtemperature not flagged");
    cool_clears_a: assert property (
        held_s(bias_power_ok && !heatsink_hot) |-> !over_temp_no && !regulator_shutdown)
        else $error("overtemperature stuck");
    fan_holdoff_a: assert property (
        hold_cnt_r < FAN_HOLDOFF |-> !fan_fault_no && !lamp_fan_fault_red)
        else $error("fan fault during hold-off");
    fan_resumes_a: assert property (
        held_s(!fan_stopped) |-> !fan_fault_no)
        else $error("fan fault stuck with fan running");
    write_refused_a: assert property (
        psel && penable && pwrite && (paddr != OFS_IRQ_MASK) |-> pslverr)
        else $error("write to read-only place accepted");
endmodule
bind ssf_top ssf_top_sva #(.FAN_HOLDOFF(FAN_HOLDOFF)) u_sva (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pslverr, .bias_power_ok, .bulk_above_390v,
    .out_under_5pct, .fan_stopped, .heatsink_hot, .lamp_power_green,
    .lamp_output_fault_red, .lamp_fan_fault_red, .lamp_over_temp_amber, .src_power_nc,
    .src_power_no, .output_fault_nc, .output_fault_no, .fan_fault_nc, .fan_fault_no,
    .over_temp_nc, .over_temp_no, .regulator_shutdown);
`default_nettype wire
